// File: logic/frs_params.svh
// Timing and reset constants for the flash reset sequencer
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH
`define FRS_CLK_PERIOD_NS     40
`define FRS_PU_MIN_US         1
`define FRS_PU_MAX_US         300
`define FRS_RPH_US            35
`define FRS_RP_NS             200
`define FRS_RS_NS             50
`define FRS_RH_NS             50
// Power-up count: chosen at the minimum, rounded up; must stay under the longest time
`define FRS_PU_CYCLES         ((`FRS_PU_MIN_US * 1000 + `FRS_CLK_PERIOD_NS - 1) / `FRS_CLK_PERIOD_NS)
`define FRS_RPH_CYCLES        ((`FRS_RPH_US * 1000 + `FRS_CLK_PERIOD_NS - 1) / `FRS_CLK_PERIOD_NS)
`define FRS_RP_CYCLES         ((`FRS_RP_NS + `FRS_CLK_PERIOD_NS - 1) / `FRS_CLK_PERIOD_NS)
`define FRS_CNT_W             16
`endif

// File: logic/frs_pkg.sv
// Types shared by the flash reset sequencer
`default_nettype none
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_POR,
    FRS_HOLD,
    FRS_READY,
    FRS_WARM
  } frs_state_t;

  typedef struct packed {
    logic in_reset;
    logic active;
    logic standby;
    logic outputs_off;
    logic cmd_block;
    logic abort_op;
    logic wel_clear;
  } frs_status_t;
endpackage
`default_nettype wire

// File: logic/frs_pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module frs_pin_sync
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb
  begin
    sync_nxt  = {sync_r[1:0], pin_i};
    level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
  end

  // Pins idle high, so reset to the deasserted level
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_r  <= 3'h7;
      level_r <= 1'b1;
    end
    else
    begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;
endmodule // frs_pin_sync
`default_nettype wire

// File: logic/frs_sequencer.sv
// Power-on, warm reset and power-mode sequencer for a serial flash
`include "frs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module frs_sequencer
(
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire logic            reset_n_i,
  input  wire logic            select_n_i,
  input  wire logic            op_busy_i,
  input  wire logic            por_fail_i,
  output frs_pkg::frs_status_t status_o
);
  import frs_pkg::*;

  localparam logic [`FRS_CNT_W-1:0] PU_CNT  = `FRS_CNT_W'(`FRS_PU_CYCLES);
  localparam logic [`FRS_CNT_W-1:0] RPH_CNT = `FRS_CNT_W'(`FRS_RPH_CYCLES);
  localparam logic [`FRS_CNT_W-1:0] RP_CNT  = `FRS_CNT_W'(`FRS_RP_CYCLES);

  logic                  rst_pin;
  logic                  sel_pin;
  logic                  rst_pin_d_r;
  logic                  rst_pin_d_nxt;
  frs_state_t            state_r;
  frs_state_t            state_nxt;
  logic [`FRS_CNT_W-1:0] cnt_r;
  logic [`FRS_CNT_W-1:0] cnt_nxt;
  logic [`FRS_CNT_W-1:0] low_r;
  logic [`FRS_CNT_W-1:0] low_nxt;
  logic                  por_bad_r;
  logic                  por_bad_nxt;
  logic                  abort_nxt;
  frs_status_t           status_r;
  frs_status_t           status_nxt;
  logic                  rst_fall;

  frs_pin_sync u_rst_sync
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (reset_n_i),
    .level_o (rst_pin)
  );

  frs_pin_sync u_sel_sync
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (select_n_i),
    .level_o (sel_pin)
  );

  // Edges are taken only after the filter agrees, so single-cycle glitches never start a reset
  assign rst_fall = rst_pin_d_r & ~rst_pin;

  // Pin history: last filtered level and time spent low
  always_comb
  begin
    rst_pin_d_nxt = rst_pin;
    // Saturate so a pin held low for ever cannot wrap and fire a second abort
    if (rst_pin)
    begin
      low_nxt = '0;
    end
    else if (low_r == '1)
    begin
      low_nxt = low_r;
    end
    else
    begin
      low_nxt = low_r + 1'b1;
    end
  end

  // Edge history resets high, matching the idle pin, so no false fall follows reset
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_pin_d_r <= 1'b1;
      low_r       <= '0;
    end
    else
    begin
      rst_pin_d_r <= rst_pin_d_nxt;
      low_r       <= low_nxt;
    end
  end

  // Sequencing state
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    por_bad_nxt = por_bad_r;
    abort_nxt   = 1'b0;
    unique case (state_r)
      FRS_POR:
      begin
        if (cnt_r < PU_CNT)
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
        else
        begin
          por_bad_nxt = por_fail_i;
          cnt_nxt     = '0;
          // held reset keeps us in reset
          state_nxt   = rst_pin ? FRS_READY : FRS_HOLD;
        end
      end
      FRS_HOLD:
      begin
        if (rst_pin)
        begin
          state_nxt = FRS_READY;
        end
      end
      FRS_READY:
      begin
        if (rst_fall && por_bad_r)
        begin
          state_nxt = FRS_POR;
          cnt_nxt   = '0;
        end
        else if (rst_fall)
        begin
          state_nxt = FRS_WARM;
          cnt_nxt   = '0;
        end
      end
      FRS_WARM:
      begin
        if (low_r == RP_CNT - 1'b1)
        begin
          abort_nxt = 1'b1;
        end
        if (cnt_r < RPH_CNT)
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
        else
        begin
          cnt_nxt   = '0;
          state_nxt = rst_pin ? FRS_READY : FRS_HOLD;
        end
      end
      default:
      begin
        state_nxt = FRS_POR;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r   <= FRS_POR;
      cnt_r     <= '0;
      por_bad_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      por_bad_r <= por_bad_nxt;
    end
  end

  // Status is built from the next state so every output leaves a flip-flop in step with it
  always_comb
  begin
    status_nxt             = '0;
    status_nxt.in_reset    = (state_nxt != FRS_READY);
    // outputs off and commands blocked in recovery
    status_nxt.outputs_off = (state_nxt != FRS_READY);
    status_nxt.cmd_block   = (state_nxt != FRS_READY);
    status_nxt.abort_op    = abort_nxt;
    // latch cleared at end of any reset
    status_nxt.wel_clear   = (state_r != FRS_READY) && (state_nxt == FRS_READY);
    // active while selected or still busy
    status_nxt.active      = (state_nxt == FRS_READY) && (~sel_pin || op_busy_i);
    status_nxt.standby     = ~status_nxt.active;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_r <= '{in_reset: 1'b1, outputs_off: 1'b1, cmd_block: 1'b1, standby: 1'b1, default: 1'b0};
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  assign status_o = status_r;
endmodule // frs_sequencer
`default_nettype wire

// File: verif/frs_host.sv
// Host controller model driving the reset and select pins
`timescale 1ns/1ps
`default_nettype none
module frs_host
(
  input  wire logic clock_i,
  output var logic  reset_n_o,
  output var logic  select_n_o
);
  initial
  begin
    reset_n_o = 1'b1;
    select_n_o = 1'b1;
  end
  task sel(input logic v);
    @(posedge clock_i);
    select_n_o <= v;
  endtask
  // Deselect, 50 ns high rounded to 2 cycles
  task down;
    sel(1'b1);
    repeat (2) @(posedge clock_i);
    reset_n_o <= 1'b0;
  endtask
  // Hold high 2 cycles before any select
  task up;
    @(posedge clock_i);
    reset_n_o <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask
endmodule // frs_host
`default_nettype wire

// File: verif/frs_chk.sv
// Port assertions for the flash reset sequencer
`timescale 1ns/1ps
`default_nettype none
module frs_chk
(
  input wire logic                 clock_i,
  input wire logic                 rst_i,
  input wire logic                 reset_n_i,
  input wire frs_pkg::frs_status_t status_o
);
  import frs_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_one_mode: assert property (!(status_o.active && status_o.standby))
    else $error("active and standby together");
  a_active_ready: assert property (status_o.active |-> !status_o.in_reset)
    else $error("active during reset");
  a_reset_quiet: assert property (status_o.in_reset |-> status_o.outputs_off && status_o.cmd_block)
    else $error("outputs or commands live in reset");
  a_pu_hold: assert property ($fell(rst_i) |-> status_o.in_reset [*8])
    else $error("power-up ended early");
  a_pin_hold: assert property (status_o.in_reset && !reset_n_i |=> status_o.in_reset)
    else $error("left reset with pin low");
  a_warm_start: assert property ($fell(reset_n_i) && !status_o.in_reset |-> ##[1:8] status_o.in_reset)
    else $error("pin fall gave no reset");
  a_abort_pulse: assert property (status_o.abort_op |-> status_o.in_reset ##1 !status_o.abort_op)
    else $error("abort pulse wrong");
  a_wel_exit: assert property (status_o.wel_clear |=> !status_o.wel_clear && !status_o.in_reset)
    else $error("latch clear pulse wrong");
  cover property (status_o.abort_op);
  cover property (status_o.wel_clear);
  cover property (status_o.active);
endmodule // frs_chk
bind frs_sequencer frs_chk u_chk (.clock_i, .rst_i, .reset_n_i, .status_o);
`default_nettype wire

// File: verif/tb_frs_sequencer.sv
// Self-checking bench for the flash reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_frs_sequencer;
  import frs_pkg::*;
  logic        clock_i = 0, rst_i = 1, op_busy_i = 0, por_fail_i = 0;
  logic [1:0]  b;
  wire logic   reset_n_i, select_n_i;
  frs_status_t s;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, n, ab = 0;
  initial forever #20 clock_i = ~clock_i;
  frs_host host (.clock_i, .reset_n_o(reset_n_i), .select_n_o(select_n_i));
  frs_sequencer DUT (.clock_i, .rst_i, .reset_n_i, .select_n_i, .op_busy_i, .por_fail_i, .status_o(s));
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    ab <= ab + int'(s.abort_op === 1'b1);
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  task chk(string nm, logic [15:0] e, logic [15:0] v);
    tests_run++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task rwait;
    n = 0;
    while (s.in_reset !== 1'b0 && n < 2000)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task por(input logic f);
    @(posedge clock_i);
    rst_i <= 1'b1;
    por_fail_i <= f;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(86980));
    por(1'b0);
    rwait;
    chk("power_up", 1, n >= 25 && n < 7500);
    chk("standby", 1, s.standby);
    repeat (12)
    begin
      b = 2'($urandom);
      host.sel(b[0]);
      op_busy_i <= b[1];
      repeat (8) @(negedge clock_i);
      chk("active", !b[0] || b[1], s.active);
    end
    host.down;
    op_busy_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    host.up;
    rwait;
    chk("recovery", 1, n > 850 && n < 900);
    chk("abort", 1, ab == 1);
    repeat (3) @(negedge clock_i);
    chk("busy_active", 1, s.active);
    host.down;
    op_busy_i <= 1'b0;
    por(1'b0);
    repeat (60) @(negedge clock_i);
    chk("held", 1, s.in_reset);
    host.up;
    rwait;
    chk("ignored", 1, n < 20);
    por(1'b1);
    rwait;
    host.down;
    repeat (10) @(posedge clock_i);
    host.up;
    rwait;
    chk("full_por", 1, n < 40);
    close_out;
  end
endmodule // tb_frs_sequencer
`default_nettype wire
